// ### rtl/rpt_pkg.sv
// Shared constants and types for the ranging pulse test logic
package rpt_pkg;
	localparam int RPT_CLK_HZ       = 50000000;
	localparam int RPT_CLK_NS       = 20;
	localparam int RPT_CNT_W        = 20;
	typedef logic [RPT_CNT_W-1:0] rpt_cnt_t;
	// Trigger rate
	localparam int RPT_TRIG_RATE_HZ = 125;
	localparam int RPT_TRIG_CYC     = RPT_CLK_HZ / RPT_TRIG_RATE_HZ;
	// Pair spacing and decoder tolerance
	localparam int RPT_PAIR_NS      = 12000;
	localparam int RPT_PAIR_CYC     = RPT_PAIR_NS / RPT_CLK_NS;
	localparam int RPT_PAIR_TOL_NS  = 1000;
	localparam int RPT_PAIR_TOL_CYC = RPT_PAIR_TOL_NS / RPT_CLK_NS;
	localparam int RPT_PAIR_MIN_CYC = RPT_PAIR_CYC - RPT_PAIR_TOL_CYC;
	localparam int RPT_PAIR_MAX_CYC = RPT_PAIR_CYC + RPT_PAIR_TOL_CYC;
	// Modulating pulse
	localparam int RPT_PULSE_NS     = 4000;
	localparam int RPT_PULSE_CYC    = (RPT_PULSE_NS + RPT_CLK_NS - 1) / RPT_CLK_NS;
	localparam int RPT_MOD_DLY_CYC  = 1;
	// Delayed coincidence gate
	localparam int RPT_GATE_DLY_NS  = 62000;
	localparam int RPT_GATE_DLY_CYC = RPT_GATE_DLY_NS / RPT_CLK_NS;
	localparam int RPT_GATE_WID_NS  = 8000;
	localparam int RPT_GATE_WID_CYC = RPT_GATE_WID_NS / RPT_CLK_NS;
	// Simulated range delays
	localparam int RPT_NS_PER_MILE  = 12360;
	localparam int RPT_NEAR_MILES   = 0;
	localparam int RPT_FAR_MILES    = 100;
	localparam int RPT_NEAR_RAW     = RPT_NEAR_MILES * RPT_NS_PER_MILE / RPT_CLK_NS;
	localparam int RPT_NEAR_CYC     = (RPT_NEAR_RAW < 1) ? 1 : RPT_NEAR_RAW;
	localparam int RPT_FAR_CYC      = RPT_FAR_MILES * RPT_NS_PER_MILE / RPT_CLK_NS;
	localparam int RPT_ONE_CYC      = 1;
	// Reply rate window
	localparam int RPT_HIST_W       = 16;
	localparam int RPT_HITS_W       = 5;
	localparam int RPT_PROD_W       = 12;
	localparam int RPT_PASS_PCT     = 70;
	localparam int RPT_PCT_FULL     = 100;
	// Register port
	localparam int RPT_ADDR_W       = 8;
	localparam int RPT_DATA_W       = 32;
	localparam logic [RPT_ADDR_W-1:0] RPT_CTRL_OFS     = 8'h00;
	localparam logic [RPT_ADDR_W-1:0] RPT_STATUS_OFS   = 8'h04;
	localparam logic [RPT_ADDR_W-1:0] RPT_IRQ_STAT_OFS = 8'h08;
	localparam logic [RPT_ADDR_W-1:0] RPT_IRQ_MASK_OFS = 8'h0c;
	localparam int RPT_ST_PASS      = 0;
	localparam int RPT_ST_MOD       = 1;
	localparam int RPT_ST_DET       = 2;
	localparam int RPT_ST_HITS_LSB  = 8;
	localparam int RPT_ST_SENT_LSB  = 16;
	// Interrupt events
	localparam int RPT_IRQ_W        = 5;
	localparam int RPT_IRQ_TRIG     = 0;
	localparam int RPT_IRQ_HIT      = 1;
	localparam int RPT_IRQ_DEC      = 2;
	localparam int RPT_IRQ_REPLY    = 3;
	localparam int RPT_IRQ_PASS     = 4;

	typedef enum logic [1:0] {
		RPT_MODE_OFF    = 2'h0,
		RPT_MODE_QUERY  = 2'h1,
		RPT_MODE_ANSWER = 2'h2,
		RPT_MODE_LOOP   = 2'h3
	} rpt_mode_t;

	typedef struct packed {
		logic      range_far;
		logic      single;
		rpt_mode_t mode;
	} rpt_ctrl_t;

	localparam int RPT_CTRL_W = $bits(rpt_ctrl_t);
	localparam rpt_ctrl_t RPT_CTRL_RST = 4'h0;

	typedef struct packed {
		logic [RPT_ADDR_W-1:0] addr;
		logic [RPT_DATA_W-1:0] wdata;
		logic                  wr;
		logic                  rd;
	} rpt_bus_req_t;

	typedef enum logic [1:0] {
		RPT_DEC_IDLE = 2'b01,
		RPT_DEC_WAIT = 2'b10
	} rpt_dec_state_t;
endpackage

// ### rtl/rpt_sync.sv
// Two-stage synchroniser for a pin input
`timescale 1ns/100ps
module rpt_sync import rpt_pkg::*; (
	input  logic clk,
	input  logic reset,
	input  logic pin,
	output logic level
);
	logic meta_reg;
	logic level_reg;

	assign level = level_reg;

	always_ff @(posedge clk) begin
		if (reset) begin
			meta_reg  <= 1'b0;
			level_reg <= 1'b0;
		end else begin
			meta_reg  <= pin;
			level_reg <= meta_reg;
		end
	end
endmodule

// ### rtl/rpt_oneshot.sv
// Delayed one-shot: waits DLY cycles after start, then is active WID cycles
`timescale 1ns/100ps
module rpt_oneshot import rpt_pkg::*; #(
	parameter int DLY = 1,
	parameter int WID = 1
) (
	input  logic clk,
	input  logic reset,
	input  logic start,
	output logic fire,
	output logic active,
	output logic busy
);
	rpt_cnt_t cnt_reg;
	rpt_cnt_t cnt_next;
	logic     busy_reg;
	logic     busy_next;
	wire      last_cyc = busy_reg && (cnt_reg == rpt_cnt_t'(DLY + WID - 2));

	// Start is ignored while a cycle is running
	assign busy_next = busy_reg ? !last_cyc : start;
	assign cnt_next  = busy_reg ? cnt_reg + 1'b1 : '0;
	assign fire      = busy_reg && (cnt_reg == rpt_cnt_t'(DLY - 1));
	assign active    = busy_reg && (cnt_reg >= rpt_cnt_t'(DLY - 1));
	assign busy      = busy_reg;

	always_ff @(posedge clk) begin
		if (reset) begin
			busy_reg <= 1'b0;
			cnt_reg  <= '0;
		end else begin
			busy_reg <= busy_next;
			cnt_reg  <= cnt_next;
		end
	end
endmodule

// ### rtl/rpt_core.sv
// Pulse timing core of the ranging test set: interrogate, answer, loopback
//
// The address map and the strobed register port were chosen for this implementation.
`timescale 1ns/100ps

// What this block does
// - Query modes trigger about 125 times per second
// - Trigger starts encoder and gate together
// - Encoder sends pair, second 12 us later
// - Single-pulse selection sends one pulse only
// - Each encoder pulse makes 4 us modulating pulse
// - Count reply only inside 8 us gate opening 62 us after trigger
// - Measured value follows coincident reply rate
// - Pass off by default, on above 70 percent
// - Pass lights pass lamp, otherwise fail lamp
// - Decoder pulses once per correctly spaced pair
// - Reply delay runs only in answer operation
// - Reply delay simulates 0 or 100 miles
// - Delay end fires one 4 us reply pulse
// - Loopback runs both functions with same timing
// - Loopback replies only while pass asserted
module rpt_core import rpt_pkg::*; #(
	parameter int TRIG_CYC = RPT_TRIG_CYC,
	parameter int FAR_CYC  = RPT_FAR_CYC
) (
	input  logic                  clk,
	input  logic                  reset,
	input  rpt_bus_req_t          bus_req,
	output logic [RPT_DATA_W-1:0] rdata,
	input  logic                  reply_det,
	output logic                  modulate,
	output logic                  pass_relay,
	output logic                  pass_lamp,
	output logic                  fail_lamp,
	output logic                  irq
);
	////////////////////////////////////////////////////////////////////////
	// Declarations
	rpt_ctrl_t             ctrl_reg;
	logic [RPT_DATA_W-1:0] rdata_reg;
	logic [RPT_IRQ_W-1:0]  irq_stat_reg;
	logic [RPT_IRQ_W-1:0]  irq_stat_next;
	logic [RPT_IRQ_W-1:0]  irq_mask_reg;
	logic                  irq_reg;
	rpt_cnt_t              trig_cnt_reg;
	rpt_cnt_t              trig_cnt_next;
	rpt_cnt_t              enc_age_reg;
	logic                  det_prev_reg;
	logic [RPT_HIST_W-1:0] hist_reg;
	logic [RPT_HIST_W-1:0] hist_next;
	logic [RPT_HIST_W-1:0] valid_reg;
	logic [RPT_HIST_W-1:0] valid_next;
	logic                  armed_reg;
	logic                  period_hit_reg;
	logic                  period_hit_next;
	logic                  pass_reg;
	logic                  pass_next;
	logic                  fail_reg;
	logic                  modulate_reg;
	rpt_cnt_t              mod_len_reg;
	rpt_dec_state_t        dec_state_reg;
	rpt_dec_state_t        dec_state_next;
	rpt_cnt_t              dec_cnt_reg;
	rpt_cnt_t              dec_cnt_next;
	logic                  det_lvl;
	logic                  dec_pulse;
	logic                  enc_fire;
	logic                  enc_busy;
	logic                  gate_open;
	logic                  gate_busy;
	logic                  mod_active;
	logic                  near_fire;
	logic                  far_fire;
	logic [RPT_HITS_W-1:0] hits;
	logic [RPT_HITS_W-1:0] sent;

	function automatic logic [RPT_HITS_W-1:0] count_ones(input logic [RPT_HIST_W-1:0] v);
		logic [RPT_HITS_W-1:0] n;
		n = '0;
		for (int i = 0; i < RPT_HIST_W; i++) begin
			n = n + RPT_HITS_W'(v[i]);
		end
		return n;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Register port decode
	wire wr_ctrl  = bus_req.wr && (bus_req.addr == RPT_CTRL_OFS);
	wire wr_istat = bus_req.wr && (bus_req.addr == RPT_IRQ_STAT_OFS);
	wire wr_imask = bus_req.wr && (bus_req.addr == RPT_IRQ_MASK_OFS);
	wire [RPT_IRQ_W-1:0] w1c_bits = wr_istat ? bus_req.wdata[RPT_IRQ_W-1:0] : '0;
	wire [RPT_IRQ_W-1:0] mask_next = wr_imask ? bus_req.wdata[RPT_IRQ_W-1:0] : irq_mask_reg;

	wire [RPT_DATA_W-1:0] status_word =
		(RPT_DATA_W'(pass_reg) << RPT_ST_PASS) |
		(RPT_DATA_W'(modulate_reg) << RPT_ST_MOD) |
		(RPT_DATA_W'(det_lvl) << RPT_ST_DET) |
		(RPT_DATA_W'(hits) << RPT_ST_HITS_LSB) |
		(RPT_DATA_W'(sent) << RPT_ST_SENT_LSB);

	wire [RPT_DATA_W-1:0] rd_word =
		(bus_req.addr == RPT_CTRL_OFS)     ? RPT_DATA_W'(ctrl_reg) :
		(bus_req.addr == RPT_STATUS_OFS)   ? status_word :
		(bus_req.addr == RPT_IRQ_STAT_OFS) ? RPT_DATA_W'(irq_stat_reg) :
		(bus_req.addr == RPT_IRQ_MASK_OFS) ? RPT_DATA_W'(irq_mask_reg) : '0;

	assign rdata = rdata_reg;

	////////////////////////////////////////////////////////////////////////
	// Mode decode
	wire query_en  = (ctrl_reg.mode == RPT_MODE_QUERY) || (ctrl_reg.mode == RPT_MODE_LOOP);
	wire answer_en = (ctrl_reg.mode == RPT_MODE_ANSWER) || (ctrl_reg.mode == RPT_MODE_LOOP);
	wire loop_en   = (ctrl_reg.mode == RPT_MODE_LOOP);

	////////////////////////////////////////////////////////////////////////
	// Trigger generator and encoder
	wire trig = query_en && (trig_cnt_reg == '0);
	assign trig_cnt_next = (!query_en || trig_cnt_reg == rpt_cnt_t'(TRIG_CYC - 1)) ? '0 :
		trig_cnt_reg + 1'b1;
	wire enc_first  = trig;
	wire enc_second = enc_fire && !ctrl_reg.single;

	// Second pulse of the pair
	rpt_oneshot #(
		.DLY (RPT_PAIR_CYC),
		.WID (RPT_ONE_CYC)
	) u_enc (
		.clk    (clk),
		.reset  (reset),
		.start  (trig),
		.fire   (enc_fire),
		.active (),
		.busy   (enc_busy)
	);

	// Delayed coincidence gate
	rpt_oneshot #(
		.DLY (RPT_GATE_DLY_CYC),
		.WID (RPT_GATE_WID_CYC)
	) u_gate (
		.clk    (clk),
		.reset  (reset),
		.start  (trig),
		.fire   (),
		.active (gate_open),
		.busy   (gate_busy)
	);

	////////////////////////////////////////////////////////////////////////
	// Detector input and coincidence
	rpt_sync u_det_sync (
		.clk   (clk),
		.reset (reset),
		.pin   (reply_det),
		.level (det_lvl)
	);

	wire det_rise = det_lvl && !det_prev_reg;
	wire hit      = query_en && gate_open && det_rise;

	////////////////////////////////////////////////////////////////////////
	// Sliding reply-rate window
	// One hit per trigger period, as the far side answers each pair once
	assign period_hit_next = trig ? hit : (period_hit_reg || hit);
	assign hist_next  = !query_en ? '0 : trig ? {hist_reg[RPT_HIST_W-2:0], period_hit_reg} : hist_reg;
	assign valid_next = !query_en ? '0 : trig ? {valid_reg[RPT_HIST_W-2:0], armed_reg} : valid_reg;
	assign hits = count_ones(hist_reg);
	assign sent = count_ones(valid_reg);

	wire [RPT_PROD_W-1:0] hit_prod  = RPT_PROD_W'(hits) * RPT_PROD_W'(RPT_PCT_FULL);
	wire [RPT_PROD_W-1:0] sent_prod = RPT_PROD_W'(sent) * RPT_PROD_W'(RPT_PASS_PCT);
	wire                  pass_cond = (sent != '0) && (hit_prod > sent_prod);
	assign pass_next = query_en && pass_cond;

	assign pass_relay = pass_reg;
	assign pass_lamp  = pass_reg;
	assign fail_lamp  = fail_reg;

	////////////////////////////////////////////////////////////////////////
	// Pair decoder
	wire dec_in_win  = (dec_cnt_reg >= rpt_cnt_t'(RPT_PAIR_MIN_CYC)) &&
		(dec_cnt_reg <= rpt_cnt_t'(RPT_PAIR_MAX_CYC));
	wire dec_timeout = dec_cnt_reg > rpt_cnt_t'(RPT_PAIR_MAX_CYC);
	wire dec_waiting = (dec_state_reg == RPT_DEC_WAIT);
	assign dec_pulse = answer_en && dec_waiting && det_rise && dec_in_win;

	always_comb begin
		dec_state_next = dec_state_reg;
		dec_cnt_next   = dec_cnt_reg + 1'b1;
		case (dec_state_reg)
			RPT_DEC_IDLE: begin
				dec_cnt_next = rpt_cnt_t'(RPT_ONE_CYC);
				if (answer_en && det_rise) begin
					dec_state_next = RPT_DEC_WAIT;
				end
			end
			RPT_DEC_WAIT: begin
				if (!answer_en || dec_pulse || dec_timeout) begin
					dec_state_next = RPT_DEC_IDLE;
				end else if (det_rise) begin
					dec_cnt_next = rpt_cnt_t'(RPT_ONE_CYC);
				end
			end
			default: begin
				dec_state_next = RPT_DEC_IDLE;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// Reply delay and interlock
	wire rdly_start = dec_pulse && answer_en;

	rpt_oneshot #(
		.DLY (RPT_NEAR_CYC),
		.WID (RPT_ONE_CYC)
	) u_near (
		.clk    (clk),
		.reset  (reset),
		.start  (rdly_start && !ctrl_reg.range_far),
		.fire   (near_fire),
		.active (),
		.busy   ()
	);

	rpt_oneshot #(
		.DLY (FAR_CYC),
		.WID (RPT_ONE_CYC)
	) u_far (
		.clk    (clk),
		.reset  (reset),
		.start  (rdly_start && ctrl_reg.range_far),
		.fire   (far_fire),
		.active (),
		.busy   ()
	);

	wire rdly_fire  = answer_en && (near_fire || far_fire);
	wire reply_fire = rdly_fire && (!loop_en || pass_reg);

	////////////////////////////////////////////////////////////////////////
	// Modulating pulse generator
	wire mod_start = enc_first || enc_second || reply_fire;

	rpt_oneshot #(
		.DLY (RPT_MOD_DLY_CYC),
		.WID (RPT_PULSE_CYC)
	) u_mod (
		.clk    (clk),
		.reset  (reset),
		.start  (mod_start),
		.fire   (),
		.active (mod_active),
		.busy   ()
	);

	assign modulate = modulate_reg;

	////////////////////////////////////////////////////////////////////////
	// Interrupts
	wire [RPT_IRQ_W-1:0] events =
		(RPT_IRQ_W'(trig) << RPT_IRQ_TRIG) |
		(RPT_IRQ_W'(hit) << RPT_IRQ_HIT) |
		(RPT_IRQ_W'(dec_pulse) << RPT_IRQ_DEC) |
		(RPT_IRQ_W'(reply_fire) << RPT_IRQ_REPLY) |
		(RPT_IRQ_W'(pass_next != pass_reg) << RPT_IRQ_PASS);
	// Set wins over a same-cycle clear
	assign irq_stat_next = (irq_stat_reg & ~w1c_bits) | events;
	assign irq = irq_reg;

	////////////////////////////////////////////////////////////////////////
	// Registers
	always_ff @(posedge clk) begin
		if (reset) begin
			ctrl_reg     <= RPT_CTRL_RST;
			rdata_reg    <= '0;
			irq_stat_reg <= '0;
			irq_mask_reg <= '0;
			irq_reg      <= 1'b0;
		end else begin
			if (wr_ctrl) begin
				ctrl_reg <= rpt_ctrl_t'(bus_req.wdata[RPT_CTRL_W-1:0]);
			end
			rdata_reg    <= bus_req.rd ? rd_word : '0;
			irq_stat_reg <= irq_stat_next;
			irq_mask_reg <= mask_next;
			irq_reg      <= |(irq_stat_next & mask_next);
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			trig_cnt_reg   <= '0;
			enc_age_reg    <= '0;
			det_prev_reg   <= 1'b0;
			hist_reg       <= '0;
			valid_reg      <= '0;
			armed_reg      <= 1'b0;
			period_hit_reg <= 1'b0;
			pass_reg       <= 1'b0;
			fail_reg       <= 1'b1;
		end else begin
			trig_cnt_reg   <= trig_cnt_next;
			enc_age_reg    <= trig ? rpt_cnt_t'(RPT_ONE_CYC) : enc_age_reg + 1'b1;
			det_prev_reg   <= det_lvl;
			hist_reg       <= hist_next;
			valid_reg      <= valid_next;
			armed_reg      <= query_en && (armed_reg || trig);
			period_hit_reg <= query_en && period_hit_next;
			pass_reg       <= pass_next;
			fail_reg       <= !pass_next;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			modulate_reg  <= 1'b0;
			mod_len_reg   <= '0;
			dec_state_reg <= RPT_DEC_IDLE;
			dec_cnt_reg   <= '0;
		end else begin
			modulate_reg  <= mod_active;
			mod_len_reg   <= modulate_reg ? mod_len_reg + 1'b1 : '0;
			dec_state_reg <= dec_state_next;
			dec_cnt_reg   <= dec_cnt_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Assertions
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	trig_period_a: assert property (trig |-> trig_cnt_reg == '0 && query_en)
		else $error("trigger outside period start");
	trig_fanout_a: assert property (trig |=> gate_busy && enc_busy)
		else $error("trigger did not start encoder and gate");
	pair_spacing_a: assert property (enc_second |-> enc_age_reg == rpt_cnt_t'(RPT_PAIR_CYC))
		else $error("second pulse not at pair spacing");
	single_mode_a: assert property (ctrl_reg.single && $stable(ctrl_reg) |-> !enc_second)
		else $error("second pulse in single mode");
	mod_width_a: assert property ($fell(modulate_reg) |-> mod_len_reg == rpt_cnt_t'(RPT_PULSE_CYC))
		else $error("modulating pulse has wrong length");
	coinc_gate_a: assert property (hit |-> gate_open && det_lvl && !$past(det_lvl))
		else $error("reply counted outside gate");
	pass_level_a: assert property (pass_reg |-> $past(query_en) && $past(hit_prod > sent_prod))
		else $error("pass without enough replies");
	lamp_drive_a: assert property (##1 (pass_lamp != fail_lamp) && (pass_relay == pass_lamp))
		else $error("lamps disagree with pass state");
	dec_window_a: assert property (dec_pulse |-> dec_waiting && dec_in_win)
		else $error("pair decoded with wrong spacing");
	reply_enable_a: assert property (rdly_start |-> answer_en)
		else $error("reply delay started outside answer");
	reply_pulse_a: assert property (reply_fire && !$past(mod_active) |=> mod_active)
		else $error("reply did not start modulating pulse");
	interlock_a: assert property (reply_fire && loop_en |-> pass_reg)
		else $error("loopback reply without pass");
endmodule

// ### dv/rpt_far_model.sv
// Airborne ranging radio model: answers pairs, sends interrogation pulses
`timescale 1ns/100ps
module rpt_far_model import rpt_pkg::*; #(
	parameter int REPLY_DLY = 2700,
	parameter int LATE_DLY  = 1500
) (
	input  logic clk,
	input  logic reset,
	input  logic modulate,
	input  logic late,
	output logic reply_det
);
	logic mod_q;
	logic ans_reg;
	logic ask_reg = 1'b0;
	int   since_reg;
	int   due_reg;
	int   wid_reg;

	////////////////////////////////////////////////////////////////////////////////
	// Reply once per received pair, ignore singles
	always_ff @(posedge clk) begin
		mod_q <= modulate;
		if (reset) begin
			since_reg <= 100000;
			due_reg <= 0;
			wid_reg <= 0;
			ans_reg <= 1'b0;
		end else begin
			if (due_reg > 0) due_reg <= due_reg - 1;
			if (modulate && !mod_q) begin
				since_reg <= 1;
				if (since_reg >= 550 && since_reg <= 650) begin
					due_reg <= late ? REPLY_DLY + LATE_DLY : REPLY_DLY;
				end
			end else if (since_reg < 100000) begin
				since_reg <= since_reg + 1;
			end
			if (due_reg == 1) wid_reg <= 50;
			else if (wid_reg > 0) wid_reg <= wid_reg - 1;
			ans_reg <= (wid_reg > 0);
		end
	end

	assign reply_det = ask_reg | ans_reg;

	////////////////////////////////////////////////////////////////////////////////
	// Interrogation pulses, 1 us wide
	task automatic send_pulses(input int gap, input int n);
		for (int i = 0; i < n; i++) begin
			ask_reg <= 1'b1;
			repeat (50) @(posedge clk);
			ask_reg <= 1'b0;
			repeat (gap - 50) @(posedge clk);
		end
	endtask
endmodule

// ### dv/test_ranging_pulse_test_logic.sv
// Testbench for the ranging pulse test logic
`timescale 1ns/100ps
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin num_errors++; \
	$display("Error at %0t: got %0h expected %0h", $time, got, exp); end end
module test_ranging_pulse_test_logic import rpt_pkg::*;;
	localparam int TRIG = 5000;
	localparam int FAR  = 100;
	// Lets a pending pair, gate and far-side reply finish after the mode is switched off
	localparam int DRAIN = 4000;
	logic                  clk = 1'b0;
	logic                  reset = 1'b1;
	logic                  late = 1'b0;
	rpt_bus_req_t          bus_req = '0;
	logic [RPT_DATA_W-1:0] rdata;
	logic                  reply_det, modulate, pass_relay, pass_lamp, fail_lamp, irq;
	logic                  mod_q = 1'b0;
	int                    num_errors = 0;
	int                    samples_checked = 0;
	int                    cyc = 0;
	int                    rises = 0;
	int                    last_rise = 0;
	int                    last_fall = 0;
	int                    near_dly = 0;

	always #10 clk = ~clk;

	rpt_core #(.TRIG_CYC(TRIG), .FAR_CYC(FAR)) dut (.clk(clk), .reset(reset), .bus_req(bus_req), .rdata(rdata),
		.reply_det(reply_det), .modulate(modulate), .pass_relay(pass_relay), .pass_lamp(pass_lamp),
		.fail_lamp(fail_lamp), .irq(irq));
	rpt_far_model far (.clk(clk), .reset(reset), .modulate(modulate), .late(late), .reply_det(reply_det));

	////////////////////////////////////////////////////////////////////////////////
	// Pulse monitor and timeout
	always @(posedge clk) begin
		cyc <= cyc + 1;
		mod_q <= modulate;
		if (modulate && !mod_q) begin
			rises <= rises + 1;
			last_rise <= cyc;
		end
		if (!modulate && mod_q) last_fall <= cyc;
		if (cyc == 100000) begin
			num_errors++;
			close_out();
		end
	end

	task automatic close_out;
		$display("Checks: %0d, errors: %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Bus and timing helpers
	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		bus_req <= {a, d, 1'b1, 1'b0};
		@(posedge clk);
		bus_req <= '0;
	endtask

	task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk);
		bus_req <= {a, 32'h0, 1'b0, 1'b1};
		@(posedge clk);
		bus_req <= '0;
		#1;
		d = rdata;
	endtask

	task automatic wait_rise(input int lim);
		int r;
		r = rises;
		for (int i = 0; i < lim && rises == r; i++) @(posedge clk);
		#1;
	endtask

	task automatic answer(input logic [31:0] ctrl, input int gap, input int n, input int exp_n, output int dly);
		int r0;
		int t0;
		bus_wr(RPT_CTRL_OFS, ctrl);
		r0 = rises;
		t0 = cyc;
		far.send_pulses(gap, n);
		step(1);
		`CHK(rises - r0, exp_n)
		dly = last_rise - t0 - gap;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Scenarios
	task automatic t_reset;
		logic [31:0] d;
		`CHK(pass_relay, 1'b0)
		`CHK(fail_lamp, 1'b1)
		`CHK(modulate, 1'b0)
		`CHK(irq, 1'b0)
		bus_rd(RPT_CTRL_OFS, d);
		`CHK(d, 32'h0)
		bus_rd(8'h10, d);
		`CHK(d, 32'h0)
	endtask

	task automatic t_query;
		int          t1;
		logic [31:0] d;
		bus_wr(RPT_CTRL_OFS, 32'h1);
		wait_rise(300);
		t1 = last_rise;
		wait_rise(700);
		`CHK(last_fall - t1, RPT_PULSE_CYC)
		`CHK(last_rise - t1, RPT_PAIR_CYC)
		wait_rise(TRIG);
		`CHK(last_rise - t1, TRIG)
		step(3 * TRIG);
		`CHK(pass_relay, 1'b1)
		`CHK(pass_lamp, 1'b1)
		`CHK(fail_lamp, 1'b0)
		bus_rd(RPT_STATUS_OFS, d);
		`CHK(d[RPT_ST_PASS], 1'b1)
		`CHK(d[RPT_ST_HITS_LSB +: RPT_HITS_W], 5'h4)
		`CHK(d[RPT_ST_SENT_LSB +: RPT_HITS_W], 5'h4)
		bus_wr(RPT_IRQ_STAT_OFS, 32'h1f);
		bus_wr(RPT_IRQ_MASK_OFS, 32'h1);
		step(2);
		`CHK(irq, 1'b0)
		for (int i = 0; i < TRIG && irq !== 1'b1; i++) @(posedge clk);
		#1;
		`CHK(irq, 1'b1)
		bus_wr(RPT_IRQ_MASK_OFS, 32'h0);
		step(2);
		`CHK(irq, 1'b0)
		bus_rd(RPT_IRQ_STAT_OFS, d);
		`CHK(d[RPT_IRQ_TRIG], 1'b1)
		`CHK(d[RPT_IRQ_HIT], 1'b1)
		bus_wr(RPT_IRQ_STAT_OFS, 32'h1);
		bus_wr(RPT_IRQ_MASK_OFS, 32'h1);
		step(2);
		`CHK(irq, 1'b0)
		bus_wr(RPT_CTRL_OFS, 32'h0);
		step(DRAIN);
	endtask

	task automatic t_single;
		int r0;
		r0 = rises;
		bus_wr(RPT_CTRL_OFS, 32'h5);
		step(2 * TRIG + 100);
		`CHK(rises - r0, 3)
		`CHK(pass_relay, 1'b0)
		bus_wr(RPT_CTRL_OFS, 32'h0);
		step(DRAIN);
	endtask

	task automatic t_late;
		logic [31:0] d;
		@(posedge clk);
		late <= 1'b1;
		bus_wr(RPT_CTRL_OFS, 32'h1);
		step(3 * TRIG);
		bus_rd(RPT_STATUS_OFS, d);
		`CHK(d[RPT_ST_HITS_LSB +: RPT_HITS_W], 5'h0)
		`CHK(pass_relay, 1'b0)
		bus_wr(RPT_CTRL_OFS, 32'h0);
		late <= 1'b0;
		step(DRAIN);
	endtask

	task automatic t_answer;
		int df;
		answer(32'h2, 600, 2, 1, near_dly);
		`CHK(last_fall - last_rise, RPT_PULSE_CYC)
		answer(32'ha, 600, 2, 1, df);
		`CHK(df - near_dly, FAR - RPT_NEAR_CYC)
		answer(32'h2, 500, 2, 0, df);
		answer(32'h2, 700, 2, 0, df);
		answer(32'h2, 580, 2, 1, df);
		answer(32'h2, 600, 1, 0, df);
		answer(32'h0, 600, 2, 0, df);
	endtask

	task automatic t_loop;
		int r0;
		int dl;
		bus_wr(RPT_CTRL_OFS, 32'h3);
		repeat (3600) @(posedge clk);
		r0 = rises;
		far.send_pulses(600, 2);
		step(1);
		`CHK(rises - r0, 0)
		step(3 * TRIG - 1203);
		`CHK(pass_relay, 1'b1)
		answer(32'h3, 600, 2, 1, dl);
		`CHK(dl, near_dly)
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		repeat (8) @(posedge clk);
		reset <= 1'b0;
		step(1);
		t_reset();
		t_query();
		t_single();
		t_late();
		t_answer();
		t_loop();
		close_out();
	end
endmodule
